// ==== common/hsh_pkg.sv ====
/*
  Shared constants and types for the high-speed host interrupt enable,
  microframe index and periodic list base register block.
  Assumes a 25 MHz controller clock and a word-wide register port that
  carries byte offsets from the controller's memory-mapped base address.
*/
package hsh_pkg;

    // clock and microframe timing
    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned UFRAME_NS       = 125000;
    localparam int unsigned UFRAME_CYCLES   = UFRAME_NS / (1000000000 / CLK_HZ);
    localparam int unsigned UFRAME_CNT_W    = 12;
    localparam logic [UFRAME_CNT_W-1:0] UFRAME_LAST =
        UFRAME_CNT_W'(UFRAME_CYCLES - 1);

    // register port geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BE_W   = 4;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS  = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE    = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_UFRAME_INDEX  = 8'h2C;
    localparam logic [ADDR_W-1:0] OFS_PERIODIC_BASE = 8'h34;

    // reset values
    localparam logic [31:0] RST_IRQ_ENABLE    = 32'h0000_0000;
    localparam logic [31:0] RST_UFRAME_INDEX  = 32'h0000_0000;
    localparam logic [31:0] RST_PERIODIC_BASE = 32'h0000_0000;
    localparam logic        RST_HALTED        = 1'h1;

    // field layout
    localparam int unsigned EVT_W        = 6;
    localparam int unsigned HALTED_BIT   = 12;
    localparam int unsigned FRIDX_W      = 14;
    localparam int unsigned SOF_LSB      = 3;
    localparam int unsigned SOF_W        = 11;
    localparam int unsigned BASE_LSB     = 12;
    localparam int unsigned BASE_W       = 20;
    localparam int unsigned LIST_IDX_W   = 10;

    // event bits that wait for the interrupt threshold (async advance,
    // transfer error, transfer done) versus those that fire at once
    localparam logic [EVT_W-1:0] DEFERRED_MASK  = 6'h23;
    localparam logic [EVT_W-1:0] IMMEDIATE_MASK = 6'h1C;

    // frame list size codes
    localparam logic [1:0] LIST_SIZE_1024 = 2'h0;
    localparam logic [1:0] LIST_SIZE_512  = 2'h1;
    localparam logic [1:0] LIST_SIZE_256  = 2'h2;

    // one bit per status event, bit 5 down to bit 0
    typedef struct packed {
        logic async_advance;
        logic system_error;
        logic list_wrap;
        logic port_change;
        logic transfer_error;
        logic transfer_done;
    } hsh_evt_t;

    // register port request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [BE_W-1:0]   be;
        logic [DATA_W-1:0] wdata;
    } hsh_req_t;

    // 64-bit address of the current periodic frame list entry
    typedef struct packed {
        logic [31:0] hi;
        logic [31:0] lo;
    } hsh_fetch_t;

endpackage : hsh_pkg

// ==== hdl/hsh_regs.sv ====
/*
  Interrupt enable mask, event status, microframe index counter and
  periodic list base registers of the high-speed host controller, with
  the host interrupt request, start-of-frame number and frame list
  entry address they produce.
  Assumes the register port, schedule engine and command register all
  run on mclk; event inputs are one-cycle pulses.
*/
// Notes on behaviour
// - host interrupt needs an enable bit and its matching pending status both set
// - events always latch into status, whatever the enable says
// - async advance, transfer error, transfer done interrupts wait for threshold tick
// - system error, list wrap, port change interrupt at once when enabled and pending
// - interrupt request drops once software clears the status bit
// - frame index advances once each 125 us microframe, at its end
// - frame index is 14 bits in 13..0, upper bits read zero
// - start-of-frame number is frame index bits 13..3
// - list index is bits N..3, N = 12, 11, 10 for size codes 0, 1, 2
// - each list entry serves eight consecutive microframes
// - frame index accepts writes only while halted
// - written frame index also sets later start-of-frame numbers
// - list base holds address bits 31..12, low 12 bits reserved zero
// - base combined with frame index walks the frame list in order
// - with wide addressing, upper fetch address comes from the segment input
// - status bits clear only on a written one
// - halted resets to one, zero while running, one again after stop
// - list wrap status sets when the list index wraps to zero
`timescale 1ns/1ps
module hsh_regs
    import hsh_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire hsh_pkg::hsh_req_t   req,
    output logic [hsh_pkg::DATA_W-1:0] rdata,
    output logic                     rvalid,
    input  wire hsh_pkg::hsh_evt_t   evt_in,
    input  wire logic                irq_threshold_tick,
    input  wire logic                run_stop_control,
    input  wire logic                sched_stopped,
    input  wire logic [1:0]          list_size_code,
    input  wire logic                wide_addressing_capable,
    input  wire logic [31:0]         upper_address_segment,
    output logic                     host_irq,
    output logic                     halted_flag,
    output logic                     uframe_tick,
    output logic [hsh_pkg::SOF_W-1:0] sof_frame_num,
    output hsh_pkg::hsh_fetch_t      list_entry_addr
);
    import hsh_pkg::*;

    // whole state of the block, apart from the microframe timer count
    typedef struct packed {
        logic [EVT_W-1:0]   status;
        logic               halted;
        logic [EVT_W-1:0]   enable;
        logic [FRIDX_W-1:0] fridx;
        logic [BASE_W-1:0]  base;
        logic               deferred;
        logic               irq;
        logic [DATA_W-1:0]  rdata;
        logic               rvalid;
        logic               tick;
        logic [SOF_W-1:0]   sof;
        hsh_fetch_t         fetch;
    } hsh_state_t;

    hsh_state_t st_q;
    hsh_state_t st_d;
    logic       tmr_tick;

    // merge written bytes into an old word under the byte enables
    function automatic logic [DATA_W-1:0] merge_bytes(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [BE_W-1:0]   be
    );
        logic [DATA_W-1:0] res;
        res = old_v;
        for (int i = 0; i < BE_W; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // mask of frame index bits N..0 for a list size code
    function automatic logic [FRIDX_W-1:0] idx_mask(input logic [1:0] code);
        logic [FRIDX_W-1:0] m;
        case (code)
            LIST_SIZE_512: m = 14'h0FFF;  // N = 11
            LIST_SIZE_256: m = 14'h07FF;  // N = 10
            default:       m = 14'h1FFF;  // N = 12, reserved code behaves as 1024
        endcase
        return m;
    endfunction : idx_mask

    // list index bits N..3, low aligned, zero above N
    function automatic logic [LIST_IDX_W-1:0] list_index(
        input logic [FRIDX_W-1:0] fi,
        input logic [1:0]         code
    );
        logic [FRIDX_W-1:0] masked;
        masked = fi & idx_mask(code);
        return masked[SOF_LSB +: LIST_IDX_W];
    endfunction : list_index

    // microframe timer only runs while the controller is not halted
    hsh_uframe_timer u_timer (
        .mclk (mclk),
        .rst  (rst),
        .run  (!st_q.halted),
        .tick (tmr_tick)
    );

    // next-state logic
    always_comb begin
        logic [EVT_W-1:0]      set_v;
        logic [EVT_W-1:0]      clr_v;
        logic [DATA_W-1:0]     word;
        logic [FRIDX_W-1:0]    fi_next;
        logic [FRIDX_W-1:0]    msk;
        logic                  wr_hit_sts;
        logic                  wr_hit_en;
        logic                  wr_hit_fi;
        logic                  wr_hit_base;
        logic                  def_active;
        logic                  imm_active;
        logic [LIST_IDX_W-1:0] lidx;

        st_d        = st_q;
        set_v       = '0;
        clr_v       = '0;
        word        = '0;
        fi_next     = st_q.fridx;
        msk         = idx_mask(list_size_code);
        wr_hit_sts  = req.wr && (req.addr == OFS_EVENT_STATUS);
        wr_hit_en   = req.wr && (req.addr == OFS_IRQ_ENABLE);
        wr_hit_fi   = req.wr && (req.addr == OFS_UFRAME_INDEX);
        wr_hit_base = req.wr && (req.addr == OFS_PERIODIC_BASE);

        // halted follows run/stop and the engine's stop report
        if (run_stop_control) begin
            st_d.halted = 1'b0;
        end else if (sched_stopped) begin
            st_d.halted = 1'b1;
        end

        // microframe index: software load while halted, else count
        if (wr_hit_fi && st_q.halted) begin
            word    = merge_bytes({18'h0, st_q.fridx}, req.wdata, req.be);
            fi_next = word[FRIDX_W-1:0];
        end else if (tmr_tick) begin
            fi_next = st_q.fridx + FRIDX_W'(1);
            if ((st_q.fridx & msk) == msk) begin
                set_v[3] = 1'b1;
            end
        end
        st_d.fridx = fi_next;

        // status events: hardware sets, software writes one to clear
        set_v = set_v | evt_in;
        if (wr_hit_sts) begin
            clr_v = req.wdata[EVT_W-1:0] & {EVT_W{req.be[0]}};
        end
        st_d.status = (st_q.status & ~clr_v) | set_v;

        // interrupt enable mask, reserved bits dropped
        if (wr_hit_en && req.be[0]) begin
            st_d.enable = req.wdata[EVT_W-1:0];
        end

        // periodic list base, only address bits 31..12 are held
        if (wr_hit_base) begin
            word       = merge_bytes({st_q.base, 12'h000}, req.wdata, req.be);
            st_d.base  = word[BASE_LSB +: BASE_W];
        end

        // interrupt request: deferred sources arm at a threshold tick
        def_active    = |(st_q.status & st_q.enable & DEFERRED_MASK);
        imm_active    = |(st_q.status & st_q.enable & IMMEDIATE_MASK);
        st_d.deferred = (st_q.deferred | irq_threshold_tick) && def_active;
        st_d.irq      = imm_active || (st_q.deferred && def_active);

        // outputs seen by the schedule engine
        st_d.tick = tmr_tick;
        st_d.sof  = st_q.fridx[SOF_LSB +: SOF_W];
        lidx      = list_index(st_q.fridx, list_size_code);
        st_d.fetch.lo = {st_q.base, lidx, 2'h0};
        st_d.fetch.hi = wide_addressing_capable ? upper_address_segment : 32'h0;

        // read data, answered one cycle after the read strobe
        st_d.rvalid = req.rd;
        st_d.rdata  = '0;
        if (req.rd) begin
            case (req.addr)
                OFS_EVENT_STATUS: begin
                    st_d.rdata[EVT_W-1:0]  = st_q.status;
                    st_d.rdata[HALTED_BIT] = st_q.halted;
                end
                OFS_IRQ_ENABLE: begin
                    st_d.rdata[EVT_W-1:0] = st_q.enable;
                end
                OFS_UFRAME_INDEX: begin
                    st_d.rdata[FRIDX_W-1:0] = st_q.fridx;
                end
                OFS_PERIODIC_BASE: begin
                    st_d.rdata[BASE_LSB +: BASE_W] = st_q.base;
                end
                default: begin
                    st_d.rdata = '0;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q        <= '0;
            st_q.halted <= RST_HALTED;
            st_q.enable <= RST_IRQ_ENABLE[EVT_W-1:0];
            st_q.fridx  <= RST_UFRAME_INDEX[FRIDX_W-1:0];
            st_q.base   <= RST_PERIODIC_BASE[BASE_LSB +: BASE_W];
        end else begin
            st_q <= st_d;
        end
    end

    // every output straight from the state register
    assign rdata           = st_q.rdata;
    assign rvalid          = st_q.rvalid;
    assign host_irq        = st_q.irq;
    assign halted_flag     = st_q.halted;
    assign uframe_tick     = st_q.tick;
    assign sof_frame_num   = st_q.sof;
    assign list_entry_addr = st_q.fetch;

endmodule : hsh_regs

// ==== hdl/hsh_uframe_timer.sv ====
/*
  Microframe timer: emits a one-cycle tick at the end of every 125 us
  microframe while running.
  Assumes run comes from logic on the same clock; the count restarts
  whenever run is low so the first tick lands a full period after start.
*/
`timescale 1ns/1ps
module hsh_uframe_timer
    import hsh_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic run,
    output logic      tick
);

    typedef struct packed {
        logic [UFRAME_CNT_W-1:0] cnt;
        logic                    tick;
    } hsh_tmr_state_t;

    hsh_tmr_state_t st_q;
    hsh_tmr_state_t st_d;

    // count cycles of one microframe, tick on the last one
    always_comb begin
        st_d      = st_q;
        st_d.tick = 1'b0;
        if (!run) begin
            st_d.cnt = '0;
        end else if (st_q.cnt == UFRAME_LAST) begin
            st_d.cnt  = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + UFRAME_CNT_W'(1);
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;

endmodule : hsh_uframe_timer

// ==== testbench/hsh_regs_bench.sv ====
/*
  Self-checking bench for hsh_regs: registers, interrupts, frame index.
  Assumes the software model owns the register port.
*/
`timescale 1ns/1ps
module hsh_regs_bench;
    import hsh_pkg::*;
    localparam logic [31:0] BASE = 32'h1234_5000;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    hsh_req_t    req;
    logic [31:0] rdata;
    logic        rvalid, host_irq, halted_flag, uframe_tick;
    hsh_evt_t    evt_in = '0;
    logic        thr_tick = 1'b0;
    logic        run_stop = 1'b0;
    logic        stopped = 1'b0;
    logic [1:0]  size_code = 2'h0;
    logic        wide = 1'b1;
    logic [31:0] segment = 32'h0000_00A5;
    logic [10:0] sof;
    hsh_fetch_t  entry;
    int          checks = 0;
    int          miscompares = 0;
    int          cycles = 0;
    // clock
    always #20 mclk = ~mclk;
    hsh_regs uut (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
        .evt_in(evt_in), .irq_threshold_tick(thr_tick), .run_stop_control(run_stop),
        .sched_stopped(stopped), .list_size_code(size_code),
        .wide_addressing_capable(wide), .upper_address_segment(segment),
        .host_irq(host_irq), .halted_flag(halted_flag), .uframe_tick(uframe_tick),
        .sof_frame_num(sof), .list_entry_addr(entry));
    hsh_sw_model sw (.mclk(mclk), .req(req), .rdata(rdata), .rvalid(rvalid));
    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 12000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        sw.rd(a, d);
        chk($sformatf("reg %h", a), d, e);
    endtask : rd_chk
    task automatic pulse(input hsh_evt_t e);
        evt_in = e;
        cyc(1);
        evt_in = '0;
    endtask : pulse
    task automatic irq_is(input logic e);
        chk("host_irq", {31'h0, host_irq}, {31'h0, e});
    endtask : irq_is
    task automatic wait_tick;
        for (int n = 0; n < 4000 && uframe_tick !== 1'b1; n++) cyc(1);
        cyc(1);
    endtask : wait_tick
    task automatic t_regs;
        rd_chk(OFS_IRQ_ENABLE, 32'h0);
        rd_chk(OFS_UFRAME_INDEX, 32'h0);
        rd_chk(OFS_PERIODIC_BASE, 32'h0);
        rd_chk(OFS_EVENT_STATUS, 32'h1000);
        rd_chk(8'h40, 32'h0);
        sw.wr(OFS_IRQ_ENABLE, 32'h3F);
        rd_chk(OFS_IRQ_ENABLE, 32'h3F);
        sw.wr(OFS_PERIODIC_BASE, BASE);
        rd_chk(OFS_PERIODIC_BASE, BASE);
        sw.wr(OFS_UFRAME_INDEX, 32'h3FFF);
        rd_chk(OFS_UFRAME_INDEX, 32'h3FFF);
        $display("register test done");
    endtask : t_regs
    task automatic t_irq;
        sw.wr(OFS_IRQ_ENABLE, 32'h04);
        pulse(6'h04);
        cyc(1);
        irq_is(1'b1);
        sw.wr(OFS_EVENT_STATUS, 32'h0);
        cyc(1);
        irq_is(1'b1);
        sw.wr(OFS_EVENT_STATUS, 32'h04);
        cyc(1);
        irq_is(1'b0);
        sw.wr(OFS_IRQ_ENABLE, 32'h0);
        pulse(6'h3F);
        rd_chk(OFS_EVENT_STATUS, 32'h103F);
        irq_is(1'b0);
        sw.wr(OFS_IRQ_ENABLE, 32'h01);
        cyc(3);
        irq_is(1'b0);
        thr_tick = 1'b1;
        cyc(1);
        thr_tick = 1'b0;
        cyc(1);
        irq_is(1'b1);
        sw.wr(OFS_EVENT_STATUS, 32'h3F);
        cyc(1);
        irq_is(1'b0);
        rd_chk(OFS_EVENT_STATUS, 32'h1000);
        sw.wr(OFS_IRQ_ENABLE, 32'h0);
        $display("interrupt test done");
    endtask : t_irq
    task automatic t_list;
        for (int c = 0; c < 3; c++) begin
            size_code = c[1:0];
            cyc(2);
            chk("entry lo", entry.lo, BASE | ((32'h3FF >> c) << 2));
            chk("entry hi", entry.hi, segment);
        end
        chk("sof", {21'h0, sof}, 32'h7FF);
        size_code = 2'h0;
        $display("list test done");
    endtask : t_list
    task automatic t_run;
        sw.wr(OFS_UFRAME_INDEX, 32'h3FFE);
        run_stop = 1'b1;
        cyc(2);
        chk("halted", {31'h0, halted_flag}, 32'h0);
        sw.wr(OFS_UFRAME_INDEX, 32'h0123);
        rd_chk(OFS_UFRAME_INDEX, 32'h3FFE);
        wait_tick();
        rd_chk(OFS_UFRAME_INDEX, 32'h3FFF);
        rd_chk(OFS_EVENT_STATUS, 32'h0);
        wait_tick();
        rd_chk(OFS_UFRAME_INDEX, 32'h0);
        rd_chk(OFS_EVENT_STATUS, 32'h8);
        chk("sof", {21'h0, sof}, 32'h0);
        chk("entry lo", entry.lo, BASE);
        run_stop = 1'b0;
        stopped = 1'b1;
        for (int n = 0; n < 100 && halted_flag !== 1'b1; n++) cyc(1);
        chk("halted", {31'h0, halted_flag}, 32'h1);
        $display("run test done");
    endtask : t_run
    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    // main sequence
    initial begin
        cyc(2);
        rst = 1'b0;
        t_regs();
        t_irq();
        t_list();
        t_run();
        complete_run();
    end
endmodule : hsh_regs_bench

// ==== testbench/hsh_regs_sva.sv ====
/*
  Port checker for hsh_regs: interrupt, halt, microframe and read rules.
  Assumes one clock domain; bound to every hsh_regs below.
*/
`timescale 1ns/1ps
module hsh_regs_sva
    import hsh_pkg::*;
(
    input wire logic                      mclk,
    input wire logic                      rst,
    input wire hsh_pkg::hsh_req_t         req,
    input wire logic [hsh_pkg::DATA_W-1:0] rdata,
    input wire logic                      rvalid,
    input wire hsh_pkg::hsh_evt_t         evt_in,
    input wire logic                      irq_threshold_tick,
    input wire logic                      run_stop_control,
    input wire logic                      wide_addressing_capable,
    input wire logic [31:0]               upper_address_segment,
    input wire logic                      host_irq,
    input wire logic                      halted_flag,
    input wire logic                      uframe_tick,
    input wire logic [hsh_pkg::SOF_W-1:0] sof_frame_num,
    input wire hsh_pkg::hsh_fetch_t       list_entry_addr
);
    logic [11:0] gap_q;
    logic        seen_q;
    // cycles since the last tick, trusted only while running
    always_ff @(posedge mclk) begin
        gap_q  <= uframe_tick ? 12'h000 : gap_q + 12'h001;
        seen_q <= !rst && !halted_flag && (seen_q || uframe_tick);
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_irq_rise;
        $rose(host_irq) |-> $past(|evt_in, 2) || $past(irq_threshold_tick, 2) || $past(req.wr, 2);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    property p_irq_fall;
        $fell(host_irq) |-> $past(req.wr, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
    property p_run_halt;
        run_stop_control |=> !halted_flag;
    endproperty
    a_run_halt: assert property (p_run_halt) else $error("halted while running");
    property p_stay_halt;
        halted_flag && !run_stop_control |=> halted_flag;
    endproperty
    a_stay_halt: assert property (p_stay_halt) else $error("halt dropped when stopped");
    property p_rst_halt;
        $fell(rst) |-> halted_flag;
    endproperty
    a_rst_halt: assert property (p_rst_halt) else $error("not halted after reset");
    property p_gap;
        uframe_tick && seen_q |-> gap_q == UFRAME_LAST;
    endproperty
    a_gap: assert property (p_gap) else $error("microframe period wrong");
    property p_sof;
        $changed(sof_frame_num) |-> $past(uframe_tick) || $past(req.wr, 2);
    endproperty
    a_sof: assert property (p_sof) else $error("frame number moved alone");
    property p_idx_rsvd;
        req.rd && req.addr == OFS_UFRAME_INDEX |=> rvalid && rdata[31:14] == 18'h00000;
    endproperty
    a_idx_rsvd: assert property (p_idx_rsvd) else $error("index upper bits set");
    property p_wide;
        wide_addressing_capable [*2] |-> list_entry_addr.hi == $past(upper_address_segment);
    endproperty
    a_wide: assert property (p_wide) else $error("upper fetch address wrong");
endmodule : hsh_regs_sva

bind hsh_regs hsh_regs_sva u_sva (.mclk, .rst, .req, .rdata, .rvalid, .evt_in,
    .irq_threshold_tick, .run_stop_control, .wide_addressing_capable,
    .upper_address_segment, .host_irq, .halted_flag, .uframe_tick, .sof_frame_num,
    .list_entry_addr);

// ==== testbench/hsh_sw_model.sv ====
/*
  Host software on the register port: whole-word writes and reads.
  Assumes each access is started just after a rising edge.
*/
`timescale 1ns/1ps
module hsh_sw_model
    import hsh_pkg::*;
(
    input  wire logic                       mclk,
    output hsh_pkg::hsh_req_t               req,
    input  wire logic [hsh_pkg::DATA_W-1:0] rdata,
    input  wire logic                       rvalid
);
    // idle port from time zero
    initial req = '0;
    // full-word write, caller keeps reserved bits zero; data scrambled after
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req.addr  = a;
        req.be    = 4'hF;
        req.wdata = d;
        req.wr    = 1'b1;
        @(posedge mclk);
        #1;
        req.wr    = 1'b0;
        req.wdata = ~d;
        // one idle edge so a following access never re-drives in this step
        @(posedge mclk);
        #1;
    endtask : wr
    // read; unknown data when no answer came
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        req.addr = a;
        req.rd   = 1'b1;
        @(posedge mclk);
        #1;
        req.rd   = 1'b0;
        d = (rvalid === 1'b1) ? rdata : 'x;
        // one idle edge so a following access never re-drives in this step
        @(posedge mclk);
        #1;
    endtask : rd
endmodule : hsh_sw_model
